// File: pkg/pss_pkg.sv
// Shared types and constants for the program sequencer and stack unit
package pss_pkg;
	localparam int PSS_PC_W = 14;
	localparam int PSS_PAGE_LSB = 8;
	localparam int PSS_HALF_BIT = 12;
	localparam logic [13:0] PSS_PC_RESET = 14'h0000;
	localparam logic [7:0] PSS_SP_RESET = 8'h00;
	localparam logic [7:0] PSS_BYTE_ONE = 8'h01;
	localparam logic [5:0] PSS_PAGE_ONE = 6'h01;
	localparam logic [7:0] PSS_SP_STEP = 8'h01;
	localparam logic [7:0] PSS_LINE_IDLE = 8'h00;

	typedef enum logic [3:0] {
		PSS_OP_NEXT = 4'h0,
		PSS_OP_PAGE = 4'h1,
		PSS_OP_JUMP = 4'h2,
		PSS_OP_CALL = 4'h3,
		PSS_OP_RET = 4'h4,
		PSS_OP_INTERRUPT_RETURN_OP = 4'h5,
		PSS_OP_SP_LOAD = 4'h6,
		PSS_OP_ACC_LOAD = 4'h7,
		PSS_OP_IDX_LOAD = 4'h8,
		PSS_OP_INDEXED = 4'h9,
		PSS_OP_DI = 4'hA,
		PSS_OP_EI = 4'hB
	} pss_op_t;

	typedef enum logic [5:0] {
		PSS_IDLE = 6'b00_0001,
		PSS_PUSH2 = 6'b00_0010,
		PSS_POP_LO = 6'b00_0100,
		PSS_POP_HI = 6'b00_1000,
		PSS_POP_END = 6'b01_0000,
		PSS_SPARE = 6'b10_0000
	} pss_fsm_t;

	typedef struct packed {
		logic valid;
		pss_op_t op;
		logic two_byte;
		logic [13:0] target;
		logic [7:0] imm;
	} pss_cmd_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} pss_ram_t;

	typedef struct packed {
		logic ps2_clock_line;
		logic ps2_data_line;
		logic [1:0] usb_lines;
		logic capture_a;
		logic capture_b;
		logic port2_bit0;
	} pss_pins_t;

	typedef struct packed {
		pss_fsm_t fsm;
		logic [13:0] instr_pointer;
		logic [7:0] call_stack_pointer;
		logic [7:0] acc;
		logic [7:0] index_reg;
		logic [7:0] operand_addr;
		logic carry;
		logic zero;
		logic int_enable;
		logic interrupt_return_op_pending;
		logic [13:0] branch_pc;
		logic [7:0] low_byte;
		logic int_ack;
		logic cross_fault;
		logic busy;
		pss_ram_t ram;
		pss_pins_t pins;
	} pss_state_t;
endpackage

`default_nettype wire

// File: verilog/pss_sequencer.sv
// Program counter, call stack, accumulator and index register sequencer
`timescale 1ns/10ps
`default_nettype none

module pss_sequencer import pss_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic clk_en,
	input wire pss_cmd_t cmd,
	input wire logic carry_in,
	input wire logic zero_in,
	input wire logic irq,
	input wire logic [13:0] irq_vector,
	input wire logic [7:0] ram_rdata,
	input wire logic ps2_mode,
	input wire logic usb_dp_in,
	input wire logic usb_dm_in,
	input wire logic [1:0] port0_low_in,
	input wire logic pullup_supply_pin,
	output logic [13:0] instr_pointer,
	output logic [7:0] call_stack_pointer,
	output logic [7:0] acc,
	output logic [7:0] index_reg,
	output logic [7:0] operand_addr,
	output logic carry,
	output logic zero,
	output logic int_enable,
	output logic int_ack,
	output logic cross_fault,
	output logic busy,
	output pss_ram_t ram,
	output pss_pins_t pins
);
	pss_state_t st_q;
	pss_state_t st_d;
	logic idle;
	logic take_int;
	logic take_cmd;
	logic [13:0] next_pc;

	assign idle = (st_q.fsm == PSS_IDLE);
	assign take_int = idle && irq && st_q.int_enable;
	assign take_cmd = idle && cmd.valid && !take_int;

	// Low byte wraps inside the page; page bits are never carried into
	always_comb begin
		next_pc = st_q.instr_pointer;
		next_pc[PSS_PAGE_LSB-1:0] = st_q.instr_pointer[PSS_PAGE_LSB-1:0] + (cmd.two_byte ? 8'h02 : PSS_BYTE_ONE);
	end

	always_comb begin
		st_d = st_q;
		st_d.int_ack = 1'b0;
		st_d.cross_fault = 1'b0;
		st_d.ram.we = 1'b0;
		st_d.ram.re = 1'b0;
		case (st_q.fsm)
			PSS_IDLE: begin
				if (take_int) begin
					// Interrupted instruction is not consumed, so the current counter is saved
					st_d.int_enable = 1'b0;
					st_d.int_ack = 1'b1;
					st_d.ram.addr = st_q.call_stack_pointer;
					st_d.ram.wdata = {carry_in, zero_in, st_q.instr_pointer[13:8]};
					st_d.ram.we = 1'b1;
					st_d.low_byte = st_q.instr_pointer[7:0];
					st_d.call_stack_pointer = st_q.call_stack_pointer + PSS_SP_STEP;
					st_d.branch_pc = irq_vector;
					st_d.fsm = PSS_PUSH2;
				end else if (take_cmd) begin
					st_d.instr_pointer = next_pc;
					case (cmd.op)
						PSS_OP_PAGE: begin
							st_d.instr_pointer[13:8] = st_q.instr_pointer[13:8] + PSS_PAGE_ONE;
						end
						PSS_OP_JUMP: begin
							st_d.instr_pointer = {st_q.instr_pointer[PSS_HALF_BIT+1:PSS_HALF_BIT],
								cmd.target[PSS_HALF_BIT-1:0]};
							st_d.cross_fault = cmd.target[PSS_HALF_BIT] != st_q.instr_pointer[PSS_HALF_BIT];
						end
						PSS_OP_CALL: begin
							st_d.ram.addr = st_q.call_stack_pointer;
							st_d.ram.wdata = {carry_in, zero_in, next_pc[13:8]};
							st_d.ram.we = 1'b1;
							st_d.low_byte = next_pc[7:0];
							st_d.call_stack_pointer = st_q.call_stack_pointer + PSS_SP_STEP;
							st_d.branch_pc = {st_q.instr_pointer[PSS_HALF_BIT+1:PSS_HALF_BIT],
								cmd.target[PSS_HALF_BIT-1:0]};
							st_d.cross_fault = cmd.target[PSS_HALF_BIT] != st_q.instr_pointer[PSS_HALF_BIT];
							st_d.fsm = PSS_PUSH2;
						end
						PSS_OP_RET, PSS_OP_INTERRUPT_RETURN_OP: begin
							st_d.interrupt_return_op_pending = (cmd.op == PSS_OP_INTERRUPT_RETURN_OP);
							st_d.call_stack_pointer = st_q.call_stack_pointer - PSS_SP_STEP;
							st_d.ram.addr = st_q.call_stack_pointer - PSS_SP_STEP;
							st_d.ram.re = 1'b1;
							st_d.fsm = PSS_POP_LO;
						end
						PSS_OP_SP_LOAD: begin
							st_d.call_stack_pointer = st_q.acc;
						end
						PSS_OP_ACC_LOAD: begin
							st_d.acc = cmd.imm;
						end
						PSS_OP_IDX_LOAD: begin
							st_d.index_reg = cmd.imm;
						end
						PSS_OP_INDEXED: begin
							st_d.operand_addr = cmd.imm + st_q.index_reg;
						end
						PSS_OP_DI: begin
							st_d.int_enable = 1'b0;
						end
						PSS_OP_EI: begin
							st_d.int_enable = 1'b1;
						end
						default: begin
						end
					endcase
				end
			end
			PSS_PUSH2: begin
				st_d.ram.addr = st_q.call_stack_pointer;
				st_d.ram.wdata = st_q.low_byte;
				st_d.ram.we = 1'b1;
				st_d.call_stack_pointer = st_q.call_stack_pointer + PSS_SP_STEP;
				st_d.instr_pointer = st_q.branch_pc;
				st_d.fsm = PSS_IDLE;
			end
			PSS_POP_LO: begin
				st_d.call_stack_pointer = st_q.call_stack_pointer - PSS_SP_STEP;
				st_d.ram.addr = st_q.call_stack_pointer - PSS_SP_STEP;
				st_d.ram.re = 1'b1;
				st_d.fsm = PSS_POP_HI;
			end
			PSS_POP_HI: begin
				st_d.low_byte = ram_rdata;
				st_d.fsm = PSS_POP_END;
			end
			PSS_POP_END: begin
				st_d.instr_pointer = {ram_rdata[5:0], st_q.low_byte};
				if (st_q.interrupt_return_op_pending) begin
					st_d.carry = ram_rdata[7];
					st_d.zero = ram_rdata[6];
					st_d.int_enable = 1'b1;
				end
				st_d.interrupt_return_op_pending = 1'b0;
				st_d.fsm = PSS_IDLE;
			end
			default: begin
				st_d.fsm = PSS_IDLE;
			end
		endcase
		st_d.busy = (st_d.fsm != PSS_IDLE);
		// Shared pads: PS/2 sees the USB pair only in PS/2 mode, USB sees it otherwise
		st_d.pins.ps2_clock_line = ps2_mode ? usb_dp_in : 1'b1;
		st_d.pins.ps2_data_line = ps2_mode ? usb_dm_in : 1'b1;
		st_d.pins.usb_lines = ps2_mode ? 2'b00 : {usb_dp_in, usb_dm_in};
		st_d.pins.capture_a = port0_low_in[0];
		st_d.pins.capture_b = port0_low_in[1];
		st_d.pins.port2_bit0 = pullup_supply_pin;
	end

	// Reset wins over the clock enable so the core always starts cleanly
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q <= '0;
			st_q.fsm <= PSS_IDLE;
			st_q.instr_pointer <= PSS_PC_RESET;
			st_q.call_stack_pointer <= PSS_SP_RESET;
			st_q.operand_addr <= PSS_LINE_IDLE;
			st_q.pins.ps2_clock_line <= 1'b1;
			st_q.pins.ps2_data_line <= 1'b1;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	// Counter has no write path except through sequencing; stack is read as plain RAM
	assign instr_pointer = st_q.instr_pointer;
	assign call_stack_pointer = st_q.call_stack_pointer;
	assign acc = st_q.acc;
	assign index_reg = st_q.index_reg;
	assign operand_addr = st_q.operand_addr;
	assign carry = st_q.carry;
	assign zero = st_q.zero;
	assign int_enable = st_q.int_enable;
	assign int_ack = st_q.int_ack;
	assign cross_fault = st_q.cross_fault;
	assign busy = st_q.busy;
	assign ram = st_q.ram;
	assign pins = st_q.pins;

	default clocking cb @(posedge mclk iff clk_en); endclocking
	default disable iff (reset);

	logic take_call;
	logic take_ret;
	logic take_interrupt_return_op;
	logic take_page;
	logic take_next;
	assign take_call = take_cmd && cmd.op == PSS_OP_CALL;
	assign take_ret = take_cmd && cmd.op == PSS_OP_RET;
	assign take_interrupt_return_op = take_cmd && cmd.op == PSS_OP_INTERRUPT_RETURN_OP;
	assign take_page = take_cmd && cmd.op == PSS_OP_PAGE;
	assign take_next = take_cmd && cmd.op == PSS_OP_NEXT;

	// Single-cycle commands watched below
	logic take_jump;
	logic take_indexed;
	logic take_idx_load;
	logic take_di;
	logic take_ei;
	assign take_jump = take_cmd && cmd.op == PSS_OP_JUMP;
	assign take_indexed = take_cmd && cmd.op == PSS_OP_INDEXED;
	assign take_idx_load = take_cmd && cmd.op == PSS_OP_IDX_LOAD;
	assign take_di = take_cmd && cmd.op == PSS_OP_DI;
	assign take_ei = take_cmd && cmd.op == PSS_OP_EI;

	chk_reset_clears: assert property ($fell(reset) |-> st_q.instr_pointer == PSS_PC_RESET &&
		st_q.call_stack_pointer == PSS_SP_RESET)
		else $error("counter or stack pointer not cleared by reset");
	chk_low_advance: assert property (take_next |=> instr_pointer[13:8] == $past(instr_pointer[13:8]) &&
		instr_pointer[7:0] == $past(instr_pointer[7:0]) + ($past(cmd.two_byte) ? 8'h02 : 8'h01))
		else $error("normal advance wrong or carried into page");
	chk_page_advance: assert property (take_page |=> instr_pointer[13:8] == $past(instr_pointer[13:8]) + 6'h01)
		else $error("page advance did not step page bits");
	chk_int_push: assert property (take_int |=> !int_enable && ram.we &&
		ram.addr == $past(call_stack_pointer) ##1 ram.we && ram.addr == $past(call_stack_pointer, 2) + 8'h01)
		else $error("interrupt push order wrong");
	chk_call_depth: assert property (take_call |-> ##2 call_stack_pointer == $past(call_stack_pointer, 2) + 8'h02)
		else $error("call did not raise stack pointer by two");
	chk_ret_flags: assert property (take_ret |-> ##4 carry == $past(carry, 4) && zero == $past(zero, 4) &&
		call_stack_pointer == $past(call_stack_pointer, 4) - 8'h02)
		else $error("return changed flags or pointer wrong");
	chk_interrupt_return_op_enable: assert property (take_interrupt_return_op |=> !int_enable [*3] ##1 int_enable &&
		call_stack_pointer == $past(call_stack_pointer, 4) - 8'h02)
		else $error("interrupt return did not re-enable in time");
	chk_sp_load: assert property (take_cmd && cmd.op == PSS_OP_SP_LOAD |=> call_stack_pointer == $past(acc))
		else $error("stack pointer not loaded from accumulator");
	chk_call_half: assert property (take_call |-> ##2 instr_pointer[12] == $past(instr_pointer[12], 2))
		else $error("call crossed the 4K half");
	chk_ps2_lines: assert property (ps2_mode |=> pins.ps2_clock_line == $past(usb_dp_in))
		else $error("PS/2 clock not taken from D+ line");

	chk_ps2_data: assert property (ps2_mode |=> pins.ps2_data_line == $past(usb_dm_in))
		else $error("PS/2 data not taken from D- line");

	chk_usb_lines: assert property (!ps2_mode |=> pins.usb_lines == {$past(usb_dp_in), $past(usb_dm_in)} &&
		pins.ps2_clock_line && pins.ps2_data_line)
		else $error("USB lines not passed through in USB mode");

	chk_capture_inputs: assert property (1'b1 |=> pins.capture_a == $past(port0_low_in[0]) &&
		pins.capture_b == $past(port0_low_in[1]))
		else $error("capture inputs not fed from port 0");

	chk_pullup_input: assert property (1'b1 |=> pins.port2_bit0 == $past(pullup_supply_pin))
		else $error("pull-up supply pin not readable");

	// Stacked byte layout must match between push and pop
	chk_call_first: assert property (take_call |=> ram.wdata == {$past(carry_in), $past(zero_in),
		$past(next_pc[PSS_PC_W-1:PSS_PAGE_LSB])})
		else $error("first stacked byte wrong on call");

	chk_call_second: assert property (take_call |-> ##2 ram.wdata == $past(next_pc[PSS_PAGE_LSB-1:0], 2))
		else $error("second stacked byte wrong on call");

	chk_call_target: assert property (take_call |-> ##2
		instr_pointer[PSS_HALF_BIT-1:0] == $past(cmd.target[PSS_HALF_BIT-1:0], 2))
		else $error("call did not branch to its target");

	chk_int_vector: assert property (take_int |-> ##2 instr_pointer == $past(irq_vector, 2))
		else $error("interrupt did not branch to its vector");

	chk_ack_pulse: assert property (take_int |=> int_ack ##1 !int_ack)
		else $error("acknowledge pulse wrong length");

	chk_ret_target: assert property (take_ret |-> ##4 instr_pointer ==
		{$past(ram_rdata[5:0]), $past(ram_rdata, 2)})
		else $error("return did not restore counter");

	chk_interrupt_return_op_flags: assert property (take_interrupt_return_op |-> ##4 carry == $past(ram_rdata[7]) &&
		zero == $past(ram_rdata[6]))
		else $error("interrupt return did not restore flags");

	chk_jump_fault: assert property (take_jump |=> cross_fault ==
		($past(cmd.target[PSS_HALF_BIT]) != $past(instr_pointer[PSS_HALF_BIT])))
		else $error("crossing flag wrong on jump");

	chk_jump_half: assert property (take_jump |=> instr_pointer[PSS_HALF_BIT] == $past(instr_pointer[PSS_HALF_BIT]))
		else $error("jump crossed the 4K half");

	chk_index_sum: assert property (take_indexed |=> operand_addr == $past(cmd.imm) + $past(index_reg))
		else $error("indexed address not base plus index");

	chk_index_load: assert property (take_idx_load |=> index_reg == $past(cmd.imm))
		else $error("index register not loaded");

	chk_int_disable: assert property (take_di |=> !int_enable)
		else $error("interrupts not disabled");

	chk_int_enable: assert property (take_ei |=> int_enable)
		else $error("interrupts not enabled");

	chk_ram_exclusive: assert property (!(ram.re && ram.we))
		else $error("stack read and write in one cycle");

	cov_call: cover property (take_call ##2 idle);
	cov_int_ack: cover property (take_int ##2 idle);
	cov_interrupt_return_op: cover property (take_interrupt_return_op ##4 int_enable);
	cov_page: cover property (take_page);
	cov_jump_cross: cover property (take_jump ##1 cross_fault);
endmodule // pss_sequencer

`default_nettype wire

// File: test/test_program_sequencer_stack.sv
// Self-checking bench for the program sequencer and stack unit
`timescale 1ns/10ps
`default_nettype none
module test_program_sequencer_stack import pss_pkg::*; ;
	logic mclk = 0;
	logic reset = 1;
	logic clk_en = 1;
	pss_cmd_t cmd = '0;
	logic carry_in = 0;
	logic zero_in = 0;
	logic irq = 0;
	logic [13:0] irq_vector = '0;
	logic [7:0] ram_rdata = '0;
	logic ps2_mode = 0;
	logic usb_dp_in = 0;
	logic usb_dm_in = 0;
	logic [1:0] port0_low_in = '0;
	logic pullup_supply_pin = 0;
	logic [13:0] instr_pointer;
	logic [7:0] call_stack_pointer, acc, index_reg, operand_addr;
	logic carry, zero, int_enable, int_ack, cross_fault, busy;
	pss_ram_t ram;
	pss_pins_t pins;
	logic [7:0] mem [256];
	int n_mismatch = 0;
	int cmp_count = 0;

	pss_sequencer pss_sequencer_inst (.mclk(mclk), .reset(reset), .clk_en(clk_en), .cmd(cmd),
		.carry_in(carry_in), .zero_in(zero_in), .irq(irq), .irq_vector(irq_vector),
		.ram_rdata(ram_rdata), .ps2_mode(ps2_mode), .usb_dp_in(usb_dp_in), .usb_dm_in(usb_dm_in),
		.port0_low_in(port0_low_in), .pullup_supply_pin(pullup_supply_pin),
		.instr_pointer(instr_pointer), .call_stack_pointer(call_stack_pointer), .acc(acc),
		.index_reg(index_reg), .operand_addr(operand_addr), .carry(carry), .zero(zero),
		.int_enable(int_enable), .int_ack(int_ack), .cross_fault(cross_fault), .busy(busy),
		.ram(ram), .pins(pins));

	always #12.5 mclk = ~mclk;

	// Data RAM; read data is not held, so a late capture sees garbage
	always @(posedge mclk) begin
		if (ram.we)
			mem[ram.addr] <= ram.wdata;
		if (ram.re)
			ram_rdata <= mem[ram.addr];
		else
			ram_rdata <= ~ram_rdata;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
		end
	endtask

	// Returns 1 ns after the taking edge
	task automatic issue(input pss_op_t o, input logic tb, input logic [13:0] t, input logic [7:0] im);
		cmd = '{1'b1, o, tb, t, im};
		step(1);
		cmd.valid = 1'b0;
	endtask

	task automatic t_reset;
		chk(instr_pointer, 16'h0000);
		chk(call_stack_pointer, 16'h0000);
		chk(int_enable, 16'h0000);
	endtask

	task automatic t_pins;
		ps2_mode = 1;
		usb_dp_in = 0;
		usb_dm_in = 1;
		port0_low_in = 2'b10;
		pullup_supply_pin = 1;
		step(2);
		chk(pins.ps2_clock_line, 16'h0000);
		chk(pins.ps2_data_line, 16'h0001);
		chk(pins.usb_lines, 16'h0000);
		chk({pins.capture_b, pins.capture_a}, 16'h0002);
		chk(pins.port2_bit0, 16'h0001);
		ps2_mode = 0;
		usb_dp_in = 1;
		usb_dm_in = 0;
		port0_low_in = 2'b01;
		pullup_supply_pin = 0;
		step(2);
		chk({pins.ps2_clock_line, pins.ps2_data_line, pins.usb_lines}, 16'h000E);
		chk({pins.capture_b, pins.capture_a}, 16'h0001);
		chk(pins.port2_bit0, 16'h0000);
	endtask

	task automatic t_advance;
		issue(PSS_OP_NEXT, 0, '0, '0);
		chk(instr_pointer, 16'h0001);
		issue(PSS_OP_NEXT, 1, '0, '0);
		chk(instr_pointer, 16'h0003);
		issue(PSS_OP_JUMP, 0, 14'h00FE, '0);
		issue(PSS_OP_NEXT, 1, '0, '0);
		chk(instr_pointer, 16'h0000);
		issue(PSS_OP_PAGE, 0, '0, '0);
		chk(instr_pointer, 16'h0101);
	endtask

	task automatic t_call_ret;
		carry_in = 1;
		issue(PSS_OP_CALL, 1, 14'h0234, '0);
		chk({ram.we, ram.addr}, 16'h0100);
		chk(ram.wdata, 16'h0081);
		step(1);
		chk({ram.we, ram.addr}, 16'h0101);
		chk(ram.wdata, 16'h0003);
		chk(call_stack_pointer, 16'h0002);
		chk({busy, 1'b0, instr_pointer}, 16'h0234);
		carry_in = 0;
		zero_in = 1;
		issue(PSS_OP_RET, 0, '0, '0);
		chk({ram.re, ram.addr}, 16'h0101);
		step(1);
		chk({ram.re, ram.addr}, 16'h0100);
		step(2);
		chk(instr_pointer, 16'h0103);
		chk({busy, call_stack_pointer}, 16'h0000);
		chk({carry, zero}, 16'h0000);
	endtask

	task automatic t_irq_interrupt_return_op;
		issue(PSS_OP_ACC_LOAD, 0, '0, 8'h40);
		issue(PSS_OP_SP_LOAD, 0, '0, '0);
		chk(call_stack_pointer, 16'h0040);
		issue(PSS_OP_EI, 0, '0, '0);
		issue(PSS_OP_JUMP, 0, 14'h0A55, '0);
		carry_in = 1;
		zero_in = 1;
		irq_vector = 14'h0345;
		irq = 1;
		step(1);
		irq = 0;
		chk({int_ack, int_enable}, 16'h0002);
		chk({ram.we, ram.addr}, 16'h0140);
		chk(ram.wdata, 16'h00CA);
		step(1);
		chk({ram.we, ram.addr}, 16'h0141);
		chk(ram.wdata, 16'h0055);
		chk(call_stack_pointer, 16'h0042);
		chk(instr_pointer, 16'h0345);
		carry_in = 0;
		zero_in = 0;
		issue(PSS_OP_INTERRUPT_RETURN_OP, 0, '0, '0);
		chk({ram.re, ram.addr}, 16'h0141);
		step(1);
		chk({ram.re, ram.addr}, 16'h0140);
		step(2);
		chk(instr_pointer, 16'h0A55);
		chk(call_stack_pointer, 16'h0040);
		chk({carry, zero, int_enable}, 16'h0007);
		issue(PSS_OP_DI, 0, '0, '0);
		chk(int_enable, 16'h0000);
	endtask

	task automatic t_index_cross;
		issue(PSS_OP_IDX_LOAD, 0, '0, 8'h03);
		issue(PSS_OP_INDEXED, 0, '0, 8'h10);
		chk({index_reg, operand_addr}, 16'h0313);
		issue(PSS_OP_JUMP, 0, 14'h1234, '0);
		chk(cross_fault, 16'h0001);
		chk(instr_pointer, 16'h0234);
	endtask

	task automatic wrap_up;
		$display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		step(4);
		reset = 0;
		t_reset();
		t_pins();
		t_advance();
		t_call_ret();
		t_irq_interrupt_return_op();
		t_index_cross();
		wrap_up();
	end

	// Whole sequence needs well under 200 cycles
	initial begin
		#(25 * 3000);
		n_mismatch++;
		wrap_up();
	end
endmodule // test_program_sequencer_stack
`default_nettype wire
